// *** bench/dtd_gen_sva.sv ***
`timescale 1ns/1ps
module dtd_gen_sva
#(
    parameter int MS_CYCLES = dtd_pkg::MS_CYCLES
)
(
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // Command and tone list
    input wire logic        cmd_start,
    input wire logic [3:0]  cmd_pin_sel,
    input wire logic        cmd_use_defaults,
    input wire logic [15:0] cmd_tone_on_duration,
    input wire logic [15:0] cmd_silence_duration,
    input wire logic        tone_valid,
    input wire logic [3:0]  tone_index,
    input wire logic        tone_last,
    // Status and pins
    input wire logic        tone_ready,
    input wire logic        busy,
    input wire logic        done,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe
);
    logic [3:0] sel_ff;
    int         on_ff;
    int         off_ff;
    int         gap_ff;
    int         quiet_ff;
    int         exp_gap;
    assign exp_gap = (on_ff + off_ff) * MS_CYCLES + 2;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // ****
    // Captured settings and timers
    // ****
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sel_ff <= 4'h0;
            on_ff  <= 0;
            off_ff <= 0;
        end
        else if (cmd_start && !busy)
        begin
            sel_ff <= cmd_pin_sel;
            on_ff  <= cmd_use_defaults ? int'(dtd_pkg::DEF_ON_MS) : int'(cmd_tone_on_duration);
            off_ff <= cmd_use_defaults ? int'(dtd_pkg::DEF_SILENCE_MS) : int'(cmd_silence_duration);
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gap_ff   <= 0;
            quiet_ff <= 0;
        end
        else
        begin
            gap_ff   <= (tone_valid && tone_ready) ? 0 : gap_ff + 1;
            quiet_ff <= (pin_out[sel_ff] || (tone_valid && tone_ready)) ? 0 : quiet_ff + 1;
        end
    end
    // ****
    // Properties
    // ****
    sequence s_start;
        cmd_start && !busy;
    endsequence
    sequence s_take;
        tone_valid && tone_ready;
    endsequence
    sequence s_end;
        ($rose(tone_ready) && $past(busy)) || $fell(busy);
    endsequence
    a_start_busy: assert property (s_start |=> busy && tone_ready) else $error("start not taken");
    a_oe_select: assert property ($past(busy) |-> pin_oe == (16'h1 << sel_ff)) else $error("bad enable");
    a_oe_release: assert property (!$past(busy) |-> pin_oe == 16'h0) else $error("enable not off");
    a_pin_masked: assert property ((pin_out & ~(16'h1 << sel_ff)) == 16'h0) else $error("wrong pin");
    a_ready_drop: assert property (s_take |=> !tone_ready) else $error("ready held");
    a_tone_time: assert property (s_end |-> gap_ff >= exp_gap - 1 && gap_ff <= exp_gap + 1)
        else $error("tone timing wrong");
    // Pin trails the state by two cycles, so the last pulse may fall two cycles into the pause
    a_silence_low: assert property (s_end |-> quiet_ff >= off_ff * MS_CYCLES - 1) else $error("silence broken");
    a_pwm_runs: assert property (s_take ##1 (on_ff * MS_CYCLES >= 400) |-> ##[1:300] pin_out[sel_ff])
        else $error("no pulses");
    a_done_pulse: assert property ($fell(busy) |-> ##[0:1] done) else $error("no done");
    a_done_once: assert property (done |-> !busy ##1 !done) else $error("done too long");
endmodule
bind dtd_generator dtd_gen_sva #(.MS_CYCLES(MS_CYCLES)) dtd_gen_sva_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .cmd_start(cmd_start), .cmd_pin_sel(cmd_pin_sel), .cmd_use_defaults(cmd_use_defaults),
    .cmd_tone_on_duration(cmd_tone_on_duration), .cmd_silence_duration(cmd_silence_duration),
    .tone_valid(tone_valid), .tone_index(tone_index), .tone_last(tone_last), .tone_ready(tone_ready),
    .busy(busy), .done(done), .pin_out(pin_out), .pin_oe(pin_oe));

// *** bench/dtd_rc_filter.sv ***
`timescale 1ns/1ps
module dtd_rc_filter
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Pins
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    // Smoothed level
    output logic      [15:0] audio
);
    logic [15:0] level_ff;
    int          nxt_level;
    // Released pin sinks through the resistor to ground
    always_comb nxt_level = int'(level_ff) + (((|(pin_out & pin_oe)) ? 65535 : 0) - int'(level_ff)) / 64;
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            level_ff <= 16'h0000;
        else
            level_ff <= nxt_level[15:0];
    end
    assign audio = level_ff;
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    localparam int MS = 20;
    typedef struct {int gap; logic [15:0] oe; bit loud;} dtd_exp_t;
    logic clk_sys = 1'b0, arst_n = 1'b0, cmd_start = 1'b0, cmd_use_defaults = 1'b0;
    logic [3:0] cmd_pin_sel = 4'h0, tone_index = 4'h0;
    logic [15:0] cmd_tone_on_duration = 16'h0000, cmd_silence_duration = 16'h0000;
    logic tone_valid = 1'b0, tone_last = 1'b0, tone_ready, busy, done;
    logic [15:0] pin_out, pin_oe, audio, oe_seen, peak;
    int fail_count = 0, num_checks = 0, gap = 0;
    bit track = 0;
    dtd_exp_t exp_q[$], e;
    always #5 clk_sys = ~clk_sys;
    dtd_generator #(.MS_CYCLES(MS)) dtd_generator_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .cmd_start(cmd_start), .cmd_pin_sel(cmd_pin_sel), .cmd_use_defaults(cmd_use_defaults),
        .cmd_tone_on_duration(cmd_tone_on_duration), .cmd_silence_duration(cmd_silence_duration),
        .tone_valid(tone_valid), .tone_index(tone_index), .tone_last(tone_last), .tone_ready(tone_ready),
        .busy(busy), .done(done), .pin_out(pin_out), .pin_oe(pin_oe));
    dtd_rc_filter dtd_rc_filter_inst (.clk_sys(clk_sys), .arst_n(arst_n), .pin_out(pin_out),
        .pin_oe(pin_oe), .audio(audio));
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****
    // Driver: one tone list, optional refused restart
    // ****
    task automatic play(logic [3:0] sel, logic dflt, logic [15:0] on, logic [15:0] off, int n, bit rnd, bit poke);
        int w;
        int eon;
        eon = dflt ? 200 : int'(on);
        @(posedge clk_sys);
        #1 {cmd_start, cmd_pin_sel, cmd_use_defaults} = {1'b1, sel, dflt};
        {cmd_tone_on_duration, cmd_silence_duration} = {on, off};
        @(posedge clk_sys);
        #1 cmd_start = 1'b0;
        for (int k = 0; k < n; k++)
        begin
            {tone_valid, tone_index, tone_last} = {1'b1, rnd ? 4'($urandom) : 4'(k), 1'(k == n - 1)};
            w = 0;
            while (tone_ready !== 1'b1 && w < 20000)
            begin
                @(posedge clk_sys);
                #1 w++;
            end
            check("tone_ready", 32'd1, tone_ready);
            exp_q.push_back('{(eon + (dflt ? 50 : int'(off))) * MS + 2, 16'h1 << sel, eon * MS >= 400});
            @(posedge clk_sys);
            #1 tone_valid = 1'b0;
            if (poke && k == 0)
                {cmd_start, cmd_pin_sel} = {1'b1, ~sel};
            @(posedge clk_sys);
            #1 cmd_start = 1'b0;
        end
        w = 0;
        while (done !== 1'b1 && w < 20000)
        begin
            @(posedge clk_sys);
            #1 w++;
        end
        check("done", 32'd1, done);
        repeat (2) @(posedge clk_sys);
        #1 check("pin_oe idle", 16'h0, pin_oe);
    endtask
    // ****
    // Monitor: per-tone length, enable and loudness
    // ****
    always @(posedge clk_sys)
    begin
        if (track && busy && !tone_ready)
        begin
            gap++;
            oe_seen = pin_oe;
            peak = (audio > peak) ? audio : peak;
        end
        else if (track)
        begin
            track = 0;
            e = exp_q.pop_front();
            num_checks++;
            if (gap < e.gap - 1 || gap > e.gap + 1)
            begin
                fail_count++;
                $display("ERROR tone gap expected %0d seen %0d", e.gap, gap);
            end
            check("pin_oe", e.oe, oe_seen);
            if (e.loud)
                check("pulses", 1'b1, peak > 16'd8000);
        end
        // Close the finished tone before a back-to-back take restarts tracking
        if (tone_valid && tone_ready)
            {track, gap, peak} = {1'b1, 32'd0, 16'h0};
    end
    initial
    begin
        void'($urandom(32'h10429ed7));
        repeat (4) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        play(4'($urandom), 1'b0, 16'd16, 16'd2, 16, 1'b0, 1'b1);
        play(4'($urandom), 1'b1, 16'($urandom), 16'($urandom), 1, 1'b1, 1'b0);
        play(4'hf, 1'b0, 16'd0, 16'd0, 2, 1'b1, 1'b0);
        play(4'h0, 1'b0, 16'd20 + 16'($urandom % 12), 16'($urandom % 4), 3, 1'b1, 1'b0);
        check("queue empty", 32'd0, exp_q.size());
        give_verdict();
    end
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end
endmodule

// *** core/dtd_generator.sv ***
`timescale 1ns/1ps
module dtd_generator
#(
    parameter int MS_CYCLES = dtd_pkg::MS_CYCLES
)
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    // Command
    input  wire logic         cmd_start,
    input  wire logic [3:0]   cmd_pin_sel,
    input  wire logic         cmd_use_defaults,
    input  wire logic [15:0]  cmd_tone_on_duration,
    input  wire logic [15:0]  cmd_silence_duration,
    // Tone list
    input  wire logic         tone_valid,
    input  wire logic [3:0]   tone_index,
    input  wire logic         tone_last,
    output logic              tone_ready,
    // Status
    output logic              busy,
    output logic              done,
    // Pins
    output logic [15:0]       pin_out,
    output logic [15:0]       pin_oe
);

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_TONE, ST_SILENT} dtd_state_t;

    localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

    dtd_state_t                   state_ff;
    dtd_state_t                   nxt_state;
    logic [3:0]                   pin_sel_ff;
    logic [15:0]                  on_dur_ff;
    logic [15:0]                  off_dur_ff;
    logic                         last_ff;
    logic [15:0]                  dur_cnt_ff;
    logic [16:0]                  ms_div_ff;
    logic [1:0]                   row_ff;
    logic [1:0]                   col_ff;
    logic [dtd_pkg::PWM_BITS-1:0] pwm_cnt_ff;
    logic [dtd_pkg::PWM_BITS-1:0] duty_ff;
    logic                         level_ff;
    logic                         done_ff;
    logic [15:0]                  pin_out_ff;
    logic [15:0]                  pin_oe_ff;
    logic                         accept;
    logic                         ms_tick;
    logic                         phase_load;
    logic                         step_en;
    logic [3:0]                   key;
    logic signed [6:0]            row_sample;
    logic signed [6:0]            col_sample;
    logic signed [7:0]            mix;

    // ************************************************************
    // Sequencer
    // ************************************************************
    assign tone_ready = (state_ff == ST_FETCH);
    assign accept     = tone_ready && tone_valid;
    assign busy       = (state_ff != ST_IDLE);
    assign done       = done_ff;
    assign phase_load = (nxt_state != state_ff);
    assign key        = dtd_pkg::dtd_key_map(tone_index); // R05

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (cmd_start)
                    nxt_state = ST_FETCH;
            ST_FETCH:
                if (accept)
                    nxt_state = ST_TONE;
            ST_TONE:
                if (dur_cnt_ff == 16'h0000)
                    nxt_state = ST_SILENT; // R03
            ST_SILENT:
                if (dur_cnt_ff == 16'h0000)
                    nxt_state = last_ff ? ST_IDLE : ST_FETCH; // R04
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Command capture
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_sel_ff <= 4'h0;
            on_dur_ff  <= dtd_pkg::DEF_ON_MS;
            off_dur_ff <= dtd_pkg::DEF_SILENCE_MS;
        end
        else if (state_ff == ST_IDLE && cmd_start)
        begin
            pin_sel_ff <= cmd_pin_sel;
            on_dur_ff  <= cmd_use_defaults ? dtd_pkg::DEF_ON_MS : cmd_tone_on_duration; // R06
            off_dur_ff <= cmd_use_defaults ? dtd_pkg::DEF_SILENCE_MS : cmd_silence_duration; // R06
        end
    end

    // Tone capture
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            row_ff  <= 2'd0;
            col_ff  <= 2'd0;
            last_ff <= 1'b0;
        end
        else if (accept)
        begin
            row_ff  <= key[3:2]; // R09
            col_ff  <= key[1:0]; // R09
            last_ff <= tone_last; // R04
        end
    end

    // ************************************************************
    // Millisecond base and duration count
    // ************************************************************
    assign ms_tick = (ms_div_ff == MS_LAST);

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            ms_div_ff <= 17'h00000;
        else if (phase_load || ms_tick)
            ms_div_ff <= 17'h00000;
        else
            ms_div_ff <= ms_div_ff + 17'h00001; // R06
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            dur_cnt_ff <= 16'h0000;
        else if (accept)
            dur_cnt_ff <= on_dur_ff; // R02
        else if (state_ff == ST_TONE && dur_cnt_ff == 16'h0000)
            dur_cnt_ff <= off_dur_ff; // R03
        else if ((state_ff == ST_TONE || state_ff == ST_SILENT) && ms_tick && dur_cnt_ff != 16'h0000)
            dur_cnt_ff <= dur_cnt_ff - 16'h0001; // R02 R03
    end

    // ************************************************************
    // Two oscillators and mixer
    // ************************************************************
    assign step_en = (state_ff == ST_TONE) && (pwm_cnt_ff == '1);

    dtd_sine_osc u_row_osc
    (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .clear   (accept),
        .step_en (step_en),
        .inc     (dtd_pkg::ROW_INC[row_ff]),
        .sample  (row_sample)
    );

    dtd_sine_osc u_col_osc
    (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .clear   (accept),
        .step_en (step_en),
        .inc     (dtd_pkg::COL_INC[col_ff]),
        .sample  (col_sample)
    );

    assign mix = 8'(row_sample) + 8'(col_sample); // R07

    // ************************************************************
    // PWM
    // ************************************************************
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            pwm_cnt_ff <= '0;
        else if (state_ff == ST_TONE)
            pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
        else
            pwm_cnt_ff <= '0;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            duty_ff <= '0;
        else if (state_ff != ST_TONE)
            duty_ff <= '0;
        else if (pwm_cnt_ff == '1)
            duty_ff <= {~mix[7], mix[6:0]}; // R08
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            level_ff <= 1'b0;
        else
            level_ff <= (state_ff == ST_TONE) && (pwm_cnt_ff < duty_ff); // R08
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            done_ff <= 1'b0;
        else
            done_ff <= (state_ff == ST_SILENT) && (nxt_state == ST_IDLE);
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    for (genvar i = 0; i < 16; i++)
    begin : g_pin
        always_ff @(posedge clk_sys or negedge arst_n)
        begin
            if (!arst_n)
            begin
                pin_out_ff[i] <= 1'b0;
                pin_oe_ff[i]  <= 1'b0;
            end
            else
            begin
                pin_out_ff[i] <= level_ff && busy && (pin_sel_ff == 4'(i)); // R08
                pin_oe_ff[i]  <= busy && (pin_sel_ff == 4'(i)); // R01
            end
        end
    end

    assign pin_out = pin_out_ff;
    assign pin_oe  = pin_oe_ff;

endmodule

// *** core/dtd_sine_osc.sv ***
`timescale 1ns/1ps
module dtd_sine_osc
(
    // Clock and reset
    input  wire logic                            clk_sys,
    input  wire logic                            arst_n,
    // Control
    input  wire logic                            clear,
    input  wire logic                            step_en,
    input  wire logic [dtd_pkg::PHASE_BITS-1:0]  inc,
    // Sample
    output logic signed [6:0]                    sample
);

    // ************************************************************
    // Quarter-wave table, amplitude 63
    // ************************************************************
    localparam logic [5:0] QTAB [16] = '{6'd3, 6'd9, 6'd15, 6'd21, 6'd27, 6'd32, 6'd38, 6'd42,
                                         6'd47, 6'd51, 6'd54, 6'd57, 6'd59, 6'd61, 6'd62, 6'd63};

    logic [dtd_pkg::PHASE_BITS-1:0] phase_ff;
    logic signed [6:0]              sample_ff;
    logic [5:0]                     top;
    logic [3:0]                     qidx;
    logic [5:0]                     mag;

    assign top    = phase_ff[dtd_pkg::PHASE_BITS-1 -: 6];
    assign qidx   = top[4] ? ~top[3:0] : top[3:0];
    assign mag    = QTAB[qidx];
    assign sample = sample_ff;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            phase_ff <= dtd_pkg::PHASE_RST;
        else if (clear)
            phase_ff <= dtd_pkg::PHASE_RST;
        else if (step_en)
            phase_ff <= phase_ff + inc; // R09
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            sample_ff <= 7'sh00;
        else if (clear)
            sample_ff <= 7'sh00;
        else if (step_en)
            sample_ff <= top[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag}); // R09
    end

endmodule

// *** include/dtd_pkg.sv ***
// Function
// [R01] Selected pin 0..15 drives while tones play, released afterwards.
// [R02] Each tone sounds for tone_on_duration units, 0 to 65535.
// [R03] Silence of silence_duration units follows each tone.
// [R04] Tone list plays in order with silence between consecutive tones.
// [R05] Index 0-9 digits, 10 star, 11 pound, 12-15 column A-D.
// [R06] Units are 1 ms; defaults 200 ms on, 50 ms silence.
// [R07] Each tone is the sum of two sine waves.
// [R08] Mixed sample sets PWM duty cycle driving the pin.
// [R09] Index maps to keypad row/column pair, one accumulator and sine each.
package dtd_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int DUR_UNIT_MS   = 1;
    localparam int MS_CYCLES     = DUR_UNIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [15:0] DEF_ON_MS      = 16'd200;
    localparam logic [15:0] DEF_SILENCE_MS = 16'd50;

    // ************************************************************
    // Synthesis
    // ************************************************************
    localparam int PWM_BITS   = 8;
    localparam int PHASE_BITS = 24;
    localparam int SAMPLE_HZ  = 1000000000 / CLK_PERIOD_NS / (1 << PWM_BITS);
    localparam logic [PHASE_BITS-1:0] PHASE_RST = 24'h000000;

    typedef logic [PHASE_BITS-1:0] dtd_inc_t;

    function automatic dtd_inc_t dtd_inc(input longint freq_hz);
        longint q;
        q = (freq_hz << PHASE_BITS) / longint'(SAMPLE_HZ);
        return q[PHASE_BITS-1:0];
    endfunction

    // Row 697/770/852/941 Hz, column 1209/1336/1477/1633 Hz
    localparam dtd_inc_t ROW_INC [4] = '{dtd_inc(697), dtd_inc(770), dtd_inc(852), dtd_inc(941)};
    localparam dtd_inc_t COL_INC [4] = '{dtd_inc(1209), dtd_inc(1336), dtd_inc(1477), dtd_inc(1633)};

    // Tone index to {row, column}
    function automatic logic [3:0] dtd_key_map(input logic [3:0] idx);
        case (idx)
            4'h0:    return {2'd3, 2'd1};
            4'h1:    return {2'd0, 2'd0};
            4'h2:    return {2'd0, 2'd1};
            4'h3:    return {2'd0, 2'd2};
            4'h4:    return {2'd1, 2'd0};
            4'h5:    return {2'd1, 2'd1};
            4'h6:    return {2'd1, 2'd2};
            4'h7:    return {2'd2, 2'd0};
            4'h8:    return {2'd2, 2'd1};
            4'h9:    return {2'd2, 2'd2};
            4'ha:    return {2'd3, 2'd0};
            4'hb:    return {2'd3, 2'd2};
            4'hc:    return {2'd0, 2'd3};
            4'hd:    return {2'd1, 2'd3};
            4'he:    return {2'd2, 2'd3};
            default: return {2'd3, 2'd3};
        endcase
    endfunction

endpackage
